// >>> hdl/asr_pkg.sv
// Constants, register map and carrier types of the asynchronous serial receiver
// Notes on behaviour
// RL1 - Start and bit recovery run on a 16x baud tick; the shift register moves once per bit.
// RL2 - Two whole characters buffered while a third one is still being received.
// RL3 - Characters reach software only through the receive data register.
// RL4 - Software enables reception with continuous receive on, synchronous mode off, port on.
// RL5 - A falling edge on the receive line starts a character.
// RL6 - Half a bit after the edge the line must still read low.
// RL7 - A start bit high at its centre is dropped silently; edge search resumes.
// RL8 - Each data bit one bit time apart, majority voted, shifted in LSB first.
// RL9 - Stop bit sampled one bit after the last data bit; low means framing error.
// RL10 - A finished character enters the FIFO at once and the receive flag rises.
// RL11 - Each read of the receive data register pops the oldest character.
// RL12 - Receive flag is high while receiving is enabled and the FIFO is not empty.
// RL13 - Interrupt request needs receive, peripheral and global enables all set.
// RL14 - Each FIFO entry keeps its own framing error; the oldest one is shown.
// RL15 - Framing error is read-only, never blocks reception, and pops with its entry.
// RL16 - Port enable off clears the framing error; receive enable off leaves it.
// RL17 - A framing error alone raises no interrupt request.
// RL18 - A third character into a full FIFO sets overrun and stops further reception.
// RL19 - Overrun clears only when receive enable or port enable goes low.
// RL20 - Nine-bit mode shifts nine bits; the ninth of the oldest entry is readable.
// RL21 - Software reads ninth bit and framing error before popping the data register.
// RL22 - LSB first, one low start bit, high stop bit, line idles high.
// RL23 - Data, ninth bit and framing error are stored and popped together.
package asr_pkg;

  // Register offsets on the plain register port
  localparam int ADDR_W = 4;
  localparam logic [ADDR_W-1:0] ADDR_RX_STATUS_CONTROL = 4'h0;
  localparam logic [ADDR_W-1:0] ADDR_RX_DATA = 4'h1;
  localparam logic [ADDR_W-1:0] ADDR_TX_STATUS_CONTROL = 4'h2;
  localparam logic [ADDR_W-1:0] ADDR_BAUD_DIV_LOW = 4'h3;
  localparam logic [ADDR_W-1:0] ADDR_BAUD_DIV_HIGH = 4'h4;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_ENABLE_1 = 4'h5;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_FLAGS_1 = 4'h6;
  localparam logic [ADDR_W-1:0] ADDR_INT_CONTROL = 4'h7;

  // Field positions
  localparam int RSC_SERIAL_PORT_ENABLE_BIT = 7;
  localparam int RSC_RX9_BIT = 6;
  localparam int RSC_CONTINUOUS_RECEIVE_ENABLE_BIT = 4;
  localparam int RSC_FRAMING_ERROR_BIT = 2;
  localparam int RSC_OVERRUN_FLAG_BIT = 1;
  localparam int RSC_RECEIVED_NINTH_BIT_BIT = 0;
  localparam int TSC_SYNC_BIT = 4;
  localparam int IE1_RECEIVE_INTERRUPT_ENABLE_BIT = 5;
  localparam int IF1_RECEIVE_FLAG_BIT = 5;
  localparam int ICN_GIE_BIT = 7;
  localparam int ICN_PERIPHERAL_INTERRUPT_ENABLE_BIT = 6;

  // Reset values
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [15:0] RESET_DIVISOR = 16'h0000;

  // Timing on the 16x tick: votes taken at phases 7, 8 and 9, decision at 9
  localparam int OVERSAMPLE = 16;
  localparam logic [3:0] PHASE_DECIDE = 4'h9;
  localparam logic [3:0] BITS_EIGHT = 4'h8;
  localparam logic [3:0] BITS_NINE = 4'h9;
  localparam logic [1:0] FIFO_DEPTH = 2'h2;

  // Register port request
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } asr_bus_req_type;

  // One FIFO entry: all three fields pop together
  typedef struct packed {
    logic ninth;
    logic [7:0] data;
    logic framing_error;
  } asr_entry_type;

  typedef enum logic [1:0] {
    RX_IDLE,
    RX_START,
    RX_DATA,
    RX_STOP
  } asr_rx_state_type;

endpackage

// >>> hdl/asr_receiver.sv
// Asynchronous serial receiver with two-entry FIFO and register port
//
// Decided for this implementation: the register offsets and strobed register access.
`timescale 1ns/1ps
`default_nettype none
module asr_receiver
  import asr_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic arst_n,
  // Register port
  input wire asr_bus_req_type bus_req,
  output logic [7:0] bus_rdata,
  // Serial line
  input wire logic receive_line_pin,
  // Receive interrupt request
  output logic rc_irq
);

  // Whole state of the block
  typedef struct packed {
    asr_rx_state_type st;
    logic [3:0] phase;
    logic [3:0] nbits;
    logic [8:0] shreg;
    logic [1:0] votes;
    logic line_prev;
    logic [15:0] baud_cnt;
    asr_entry_type [1:0] fifo;
    logic head;
    logic [1:0] count;
    logic overrun_flag;
    logic serial_port_enable;
    logic rx9;
    logic continuous_receive_enable;
    logic sync;
    logic receive_interrupt_enable;
    logic peripheral_interrupt_enable;
    logic global_interrupt_enable;
    logic [7:0] div_low;
    logic [7:0] div_high;
    logic [7:0] rdata;
  } asr_core_type;

  asr_core_type q, d;

  // Majority of three samples
  function automatic logic majority3(input logic [2:0] s);
    majority3 = (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
  endfunction

  // Register port decode
  function automatic logic hit(input asr_bus_req_type r, input logic [ADDR_W-1:0] a);
    hit = (r.addr == a);
  endfunction

  logic tick;
  logic rx_en;
  logic maj;
  logic decide;
  logic receive_flag;
  logic framing_error_top;
  logic pop;
  logic push;
  logic [1:0] cnt_after_pop;
  logic head_after_pop;
  logic [3:0] bits_total;
  asr_entry_type new_entry;
  asr_entry_type top;

  // Status seen by software and the interrupt request
  always_comb begin
    top = q.fifo[q.head];
    rx_en = q.serial_port_enable & q.continuous_receive_enable & ~q.sync;
    receive_flag = rx_en & (q.count != 2'h0); // [RL12]
    framing_error_top = (q.count != 2'h0) & top.framing_error; // [RL14]
    rc_irq = receive_flag & q.receive_interrupt_enable & q.peripheral_interrupt_enable & q.global_interrupt_enable; // [RL13] [RL17]
    bus_rdata = q.rdata;
  end

  // Next state
  always_comb begin
    d = q;
    // Divider makes the 16x tick; period is divisor + 1 system clocks
    tick = (q.baud_cnt == 16'h0000); // [RL1]
    d.baud_cnt = tick ? {q.div_high, q.div_low} : q.baud_cnt - 16'h0001;
    maj = majority3({q.votes, receive_line_pin}); // [RL8]
    decide = tick & (q.phase == PHASE_DECIDE);
    bits_total = q.rx9 ? BITS_NINE : BITS_EIGHT; // [RL20]
    push = 1'b0;
    new_entry = '0;
    if (tick) begin
      d.votes = {q.votes[0], receive_line_pin};
      d.line_prev = receive_line_pin;
      d.phase = q.phase + 4'h1;
    end

    // Character recovery
    unique case (q.st)
      RX_IDLE: begin
        // Overrun blocks new characters until it is cleared
        if (tick && rx_en && !q.overrun_flag && q.line_prev && !receive_line_pin) begin // [RL5] [RL18] [RL22]
          d.st = RX_START;
          d.phase = 4'h1;
        end
      end
      RX_START: begin
        if (decide) begin // [RL6]
          d.st = maj ? RX_IDLE : RX_DATA; // [RL7]
          d.nbits = 4'h0;
        end
      end
      RX_DATA: begin
        if (decide) begin
          d.shreg = {maj, q.shreg[8:1]}; // [RL8] [RL22]
          d.nbits = q.nbits + 4'h1;
          if (q.nbits + 4'h1 == bits_total) begin
            d.st = RX_STOP;
          end
        end
      end
      RX_STOP: begin
        // A frame cut by disabling the receiver must not land in the FIFO
        if (decide && rx_en) begin // [RL9]
          push = 1'b1;
          d.st = RX_IDLE;
        end
      end
    endcase

    // Align the shifted bits; eight-bit frames sit one place high
    new_entry.framing_error = ~maj; // [RL9] [RL15]
    new_entry.data = q.rx9 ? q.shreg[7:0] : q.shreg[8:1]; // [RL23]
    new_entry.ninth = q.rx9 & q.shreg[8]; // [RL20]

    // Register reads; answer stands for one cycle only
    d.rdata = RESET_BYTE;
    pop = 1'b0;
    if (bus_req.rd) begin
      if (hit(bus_req, ADDR_RX_STATUS_CONTROL)) begin
        d.rdata[RSC_SERIAL_PORT_ENABLE_BIT] = q.serial_port_enable;
        d.rdata[RSC_RX9_BIT] = q.rx9;
        d.rdata[RSC_CONTINUOUS_RECEIVE_ENABLE_BIT] = q.continuous_receive_enable;
        d.rdata[RSC_FRAMING_ERROR_BIT] = framing_error_top;
        d.rdata[RSC_OVERRUN_FLAG_BIT] = q.overrun_flag;
        d.rdata[RSC_RECEIVED_NINTH_BIT_BIT] = (q.count != 2'h0) & top.ninth; // [RL20]
      end else if (hit(bus_req, ADDR_RX_DATA)) begin
        d.rdata = (q.count != 2'h0) ? top.data : RESET_BYTE; // [RL3]
        pop = (q.count != 2'h0); // [RL11]
      end else if (hit(bus_req, ADDR_TX_STATUS_CONTROL)) begin
        d.rdata[TSC_SYNC_BIT] = q.sync;
      end else if (hit(bus_req, ADDR_BAUD_DIV_LOW)) begin
        d.rdata = q.div_low;
      end else if (hit(bus_req, ADDR_BAUD_DIV_HIGH)) begin
        d.rdata = q.div_high;
      end else if (hit(bus_req, ADDR_IRQ_ENABLE_1)) begin
        d.rdata[IE1_RECEIVE_INTERRUPT_ENABLE_BIT] = q.receive_interrupt_enable;
      end else if (hit(bus_req, ADDR_IRQ_FLAGS_1)) begin
        d.rdata[IF1_RECEIVE_FLAG_BIT] = receive_flag;
      end else if (hit(bus_req, ADDR_INT_CONTROL)) begin
        d.rdata[ICN_GIE_BIT] = q.global_interrupt_enable;
        d.rdata[ICN_PERIPHERAL_INTERRUPT_ENABLE_BIT] = q.peripheral_interrupt_enable;
      end
    end

    // FIFO: pop first so a read in the same cycle makes room for a push
    cnt_after_pop = pop ? q.count - 2'h1 : q.count;
    head_after_pop = pop ? ~q.head : q.head;
    d.head = head_after_pop;
    d.count = cnt_after_pop;
    if (push) begin
      if (cnt_after_pop == FIFO_DEPTH) begin
        d.overrun_flag = 1'b1; // [RL18]
      end else begin
        d.fifo[head_after_pop ^ cnt_after_pop[0]] = new_entry; // [RL2] [RL10] [RL23]
        d.count = cnt_after_pop + 2'h1;
      end
    end

    // Register writes; flag and data registers are not writable
    if (bus_req.wr) begin
      if (hit(bus_req, ADDR_RX_STATUS_CONTROL)) begin
        d.serial_port_enable = bus_req.wdata[RSC_SERIAL_PORT_ENABLE_BIT];
        d.rx9 = bus_req.wdata[RSC_RX9_BIT];
        d.continuous_receive_enable = bus_req.wdata[RSC_CONTINUOUS_RECEIVE_ENABLE_BIT];
      end else if (hit(bus_req, ADDR_TX_STATUS_CONTROL)) begin
        d.sync = bus_req.wdata[TSC_SYNC_BIT];
      end else if (hit(bus_req, ADDR_BAUD_DIV_LOW)) begin
        d.div_low = bus_req.wdata;
      end else if (hit(bus_req, ADDR_BAUD_DIV_HIGH)) begin
        d.div_high = bus_req.wdata;
      end else if (hit(bus_req, ADDR_IRQ_ENABLE_1)) begin
        d.receive_interrupt_enable = bus_req.wdata[IE1_RECEIVE_INTERRUPT_ENABLE_BIT];
      end else if (hit(bus_req, ADDR_INT_CONTROL)) begin
        d.global_interrupt_enable = bus_req.wdata[ICN_GIE_BIT];
        d.peripheral_interrupt_enable = bus_req.wdata[ICN_PERIPHERAL_INTERRUPT_ENABLE_BIT];
      end
    end

    // Receiver off: abandon any frame, FIFO kept; receive enable off clears overrun
    if (!rx_en) begin
      d.st = RX_IDLE;
    end
    if (!q.continuous_receive_enable) begin
      d.overrun_flag = 1'b0; // [RL19]
    end
    // Port off resets the port: FIFO emptied, so framing error reads clear
    if (!q.serial_port_enable) begin
      d.overrun_flag = 1'b0; // [RL19]
      d.count = 2'h0; // [RL16]
      d.head = 1'b0;
      d.st = RX_IDLE;
    end
  end

  // State register
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      q <= '0;
      q.st <= RX_IDLE;
      q.line_prev <= 1'b1;
      q.baud_cnt <= RESET_DIVISOR;
    end else begin
      q <= d;
    end
  end

  // Receive flag follows FIFO and enables
  a_flag_follows_fifo: assert property (@(posedge clk_sys) disable iff (!arst_n)
    receive_flag == (q.serial_port_enable && q.continuous_receive_enable && !q.sync && q.count != 2'h0)) // [RL12]
    else $error("receive flag does not match fifo state");

  // Interrupt request gated by all three enables
  a_irq_all_enables: assert property (@(posedge clk_sys) disable iff (!arst_n)
    rc_irq |-> (q.receive_interrupt_enable && q.peripheral_interrupt_enable && q.global_interrupt_enable && q.count != 2'h0)) // [RL13]
    else $error("interrupt request without enables");

  // Framing error alone cannot request an interrupt
  a_framing_error_no_irq: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (q.count == 2'h0) |-> !rc_irq) // [RL17]
    else $error("interrupt with empty fifo");

  // FIFO never exceeds two entries
  a_fifo_bound: assert property (@(posedge clk_sys) disable iff (!arst_n)
    q.count <= FIFO_DEPTH) // [RL2]
    else $error("fifo count above depth");

  // Read of data register pops one entry
  a_read_pops: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (bus_req.rd && bus_req.addr == ADDR_RX_DATA && q.count != 2'h0 && !push && q.serial_port_enable)
    |=> (q.count == $past(q.count) - 2'h1 && q.head != $past(q.head))) // [RL11]
    else $error("data read did not pop fifo");

  // Read data matches the entry that was on top
  a_read_data: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (bus_req.rd && bus_req.addr == ADDR_RX_DATA && q.count != 2'h0)
    |=> bus_rdata == $past(top.data)) // [RL3]
    else $error("read data is not the oldest character");

  // Start bit high at centre returns to idle without storing
  a_start_abort: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (q.st == RX_START && decide && maj && rx_en)
    |=> (q.st == RX_IDLE && !q.overrun_flag == !$past(q.overrun_flag) && q.count <= $past(q.count))) // [RL7]
    else $error("false start bit not abandoned");

  // Overrun only from a push into a full fifo
  a_overrun_set: assert property (@(posedge clk_sys) disable iff (!arst_n)
    $rose(q.overrun_flag) |-> ($past(push) && $past(q.count) == FIFO_DEPTH && q.count == FIFO_DEPTH)) // [RL18]
    else $error("overrun set without full fifo");

  // Overrun holds while both enables stay on
  a_overrun_hold: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (q.overrun_flag && q.continuous_receive_enable && q.serial_port_enable) |=> q.overrun_flag) // [RL19]
    else $error("overrun cleared while enabled");

  // Receive enable off clears overrun but keeps stored entries
  a_continuous_receive_enable_off: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (!q.continuous_receive_enable && q.serial_port_enable && !pop) |=> (!q.overrun_flag && q.count == $past(q.count))) // [RL16] [RL19]
    else $error("receive disable changed fifo or kept overrun");

  // Port off empties the fifo, so framing error reads clear
  a_serial_port_enable_off: assert property (@(posedge clk_sys) disable iff (!arst_n)
    !q.serial_port_enable |=> (!framing_error_top && q.count == 2'h0 && !q.overrun_flag)) // [RL16]
    else $error("port disable did not reset receiver");

  // Character pushed at the stop decision, in the FIFO the cycle after
  a_push_timing: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (q.st == RX_STOP && decide && q.count == 2'h0 && rx_en && !pop)
    |=> (q.count == 2'h1 && framing_error_top == !$past(maj))) // [RL9] [RL10]
    else $error("character not stored after stop bit");

endmodule
`default_nettype wire

// >>> sim/asr_tx_model.sv
// Remote serial transmitter model that drives the receive line
`timescale 1ns/1ps
`default_nettype none
module asr_tx_model (
  // Clock
  input wire logic clk_sys,
  // Serial line
  output logic line
);
  // Divisor stays 0, so one 16x tick per clock and 16 clocks per bit
  localparam int BIT_CLKS = 16;

  // Line idles high between characters
  initial begin
    line = 1'b1;
  end

  // Start bit low, data LSB first, chosen stop level, then idle high
  task automatic send(input logic [8:0] d, input int nbits, input logic stop_lvl);
    @(posedge clk_sys);
    line <= 1'b0;
    repeat (BIT_CLKS) @(posedge clk_sys);
    for (int i = 0; i < nbits; i++) begin
      line <= d[i];
      repeat (BIT_CLKS) @(posedge clk_sys);
    end
    line <= stop_lvl;
    repeat (BIT_CLKS) @(posedge clk_sys);
    line <= 1'b1;
    repeat (2 * BIT_CLKS) @(posedge clk_sys);
  endtask

  // Short low pulse that is high again before the start centre
  task automatic glitch();
    @(posedge clk_sys);
    line <= 1'b0;
    repeat (4) @(posedge clk_sys);
    line <= 1'b1;
    repeat (2 * BIT_CLKS) @(posedge clk_sys);
  endtask
endmodule
`default_nettype wire

// >>> sim/tb_top.sv
// Self-checking testbench of the asynchronous serial receiver
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) \
  begin \
    n_tests++; \
    if ((got) !== (exp)) begin \
      miscompares++; \
      $display("unexpected at %0t: got %h expected %h", $time, (got), (exp)); \
    end \
  end
module tb_top;
  import asr_pkg::*;
  localparam logic [7:0] SERIAL_PORT_ENABLE_M = 8'h1 << RSC_SERIAL_PORT_ENABLE_BIT;
  localparam logic [7:0] ON_M = SERIAL_PORT_ENABLE_M | (8'h1 << RSC_CONTINUOUS_RECEIVE_ENABLE_BIT);
  localparam logic [7:0] RX9_M = 8'h1 << RSC_RX9_BIT;
  localparam logic [7:0] FRAMING_ERROR_M = 8'h1 << RSC_FRAMING_ERROR_BIT;
  localparam logic [7:0] OVERRUN_FLAG_M = 8'h1 << RSC_OVERRUN_FLAG_BIT;
  localparam logic [7:0] FLAG_M = 8'h1 << IF1_RECEIVE_FLAG_BIT;
  logic clk_sys;
  logic arst_n;
  logic rc_irq;
  wire logic rx_line;
  asr_bus_req_type bus_req;
  logic [7:0] bus_rdata;
  int miscompares;
  int n_tests;

  asr_receiver DUT (.clk_sys(clk_sys), .arst_n(arst_n), .bus_req(bus_req), .bus_rdata(bus_rdata),
    .receive_line_pin(rx_line), .rc_irq(rc_irq));
  asr_tx_model u_tx (.clk_sys(clk_sys), .line(rx_line));

  // Clock at 100 MHz
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  // One-cycle write strobe
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    bus_req.addr <= a;
    bus_req.wdata <= d;
    bus_req.wr <= 1'b1;
    @(posedge clk_sys);
    bus_req.wr <= 1'b0;
  endtask

  // Read data only stand in the cycle after the strobe
  task automatic rd_chk(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk_sys);
    bus_req.addr <= a;
    bus_req.rd <= 1'b1;
    @(posedge clk_sys);
    bus_req.rd <= 1'b0;
    #1;
    `CHK(bus_rdata, e)
  endtask

  task automatic irq_chk(input logic e);
    @(posedge clk_sys);
    #1;
    `CHK(rc_irq, e)
  endtask

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // Reset values, unmapped place and read-only data register
  task automatic t_reset();
    wr_reg(4'h9, 8'hff);
    wr_reg(ADDR_RX_DATA, 8'h5a);
    for (int a = 0; a < 16; a++) rd_chk(4'(a), RESET_BYTE);
  endtask

  // Sync mode blocks reception; then a plain character
  task automatic t_basic();
    wr_reg(ADDR_TX_STATUS_CONTROL, 8'h1 << TSC_SYNC_BIT);
    wr_reg(ADDR_RX_STATUS_CONTROL, ON_M);
    u_tx.send(9'h0a5, 8, 1'b1);
    rd_chk(ADDR_IRQ_FLAGS_1, 8'h00);
    wr_reg(ADDR_TX_STATUS_CONTROL, 8'h00);
    u_tx.send(9'h0a5, 8, 1'b1);
    wr_reg(ADDR_IRQ_FLAGS_1, 8'h00);
    rd_chk(ADDR_IRQ_FLAGS_1, FLAG_M);
    rd_chk(ADDR_RX_STATUS_CONTROL, ON_M);
    rd_chk(ADDR_RX_DATA, 8'ha5);
    rd_chk(ADDR_IRQ_FLAGS_1, 8'h00);
  endtask

  // Request needs all three enables
  task automatic t_irq();
    wr_reg(ADDR_IRQ_ENABLE_1, 8'h1 << IE1_RECEIVE_INTERRUPT_ENABLE_BIT);
    wr_reg(ADDR_INT_CONTROL, 8'h1 << ICN_GIE_BIT);
    u_tx.send(9'h03c, 8, 1'b1);
    irq_chk(1'b0);
    wr_reg(ADDR_INT_CONTROL, (8'h1 << ICN_GIE_BIT) | (8'h1 << ICN_PERIPHERAL_INTERRUPT_ENABLE_BIT));
    irq_chk(1'b1);
    rd_chk(ADDR_RX_DATA, 8'h3c);
    irq_chk(1'b0);
    wr_reg(ADDR_IRQ_ENABLE_1, 8'h00);
  endtask

  // Bad stop then good one; status follows the oldest entry
  task automatic t_framing_error();
    u_tx.send(9'h03c, 8, 1'b0);
    u_tx.send(9'h0c3, 8, 1'b1);
    irq_chk(1'b0);
    rd_chk(ADDR_RX_STATUS_CONTROL, ON_M | FRAMING_ERROR_M);
    rd_chk(ADDR_RX_DATA, 8'h3c);
    rd_chk(ADDR_RX_STATUS_CONTROL, ON_M);
    rd_chk(ADDR_RX_DATA, 8'hc3);
  endtask

  // Third character into a full FIFO, then recovery by receive enable
  task automatic t_overrun();
    u_tx.send(9'h011, 8, 1'b1);
    u_tx.send(9'h022, 8, 1'b1);
    u_tx.send(9'h033, 8, 1'b1);
    u_tx.send(9'h044, 8, 1'b1);
    rd_chk(ADDR_RX_STATUS_CONTROL, ON_M | OVERRUN_FLAG_M);
    rd_chk(ADDR_RX_DATA, 8'h11);
    rd_chk(ADDR_RX_DATA, 8'h22);
    rd_chk(ADDR_RX_DATA, 8'h00);
    wr_reg(ADDR_RX_STATUS_CONTROL, SERIAL_PORT_ENABLE_M);
    rd_chk(ADDR_RX_STATUS_CONTROL, SERIAL_PORT_ENABLE_M);
    wr_reg(ADDR_RX_STATUS_CONTROL, ON_M);
  endtask

  // Start that is high at its centre is dropped without error
  task automatic t_glitch();
    u_tx.glitch();
    rd_chk(ADDR_RX_STATUS_CONTROL, ON_M);
    rd_chk(ADDR_IRQ_FLAGS_1, 8'h00);
    u_tx.send(9'h05a, 8, 1'b1);
    rd_chk(ADDR_RX_DATA, 8'h5a);
  endtask

  // Nine-bit characters; ninth bit pops with its entry
  task automatic t_nine();
    wr_reg(ADDR_RX_STATUS_CONTROL, ON_M | RX9_M);
    u_tx.send(9'h1a5, 9, 1'b1);
    u_tx.send(9'h05a, 9, 1'b1);
    rd_chk(ADDR_RX_STATUS_CONTROL, ON_M | RX9_M | 8'h01);
    rd_chk(ADDR_RX_DATA, 8'ha5);
    rd_chk(ADDR_RX_STATUS_CONTROL, ON_M | RX9_M);
    rd_chk(ADDR_RX_DATA, 8'h5a);
  endtask

  // Receive enable off keeps the framing error, port enable off clears it
  task automatic t_disable();
    wr_reg(ADDR_RX_STATUS_CONTROL, ON_M);
    u_tx.send(9'h0e7, 8, 1'b0);
    wr_reg(ADDR_RX_STATUS_CONTROL, SERIAL_PORT_ENABLE_M);
    rd_chk(ADDR_RX_STATUS_CONTROL, SERIAL_PORT_ENABLE_M | FRAMING_ERROR_M);
    rd_chk(ADDR_IRQ_FLAGS_1, 8'h00);
    wr_reg(ADDR_RX_STATUS_CONTROL, 8'h00);
    rd_chk(ADDR_RX_STATUS_CONTROL, 8'h00);
  endtask

  // Reset for four cycles, then the scenarios
  initial begin
    miscompares = 0;
    n_tests = 0;
    arst_n = 1'b0;
    bus_req = '0;
    repeat (4) @(posedge clk_sys);
    arst_n <= 1'b1;
    t_reset();
    t_basic();
    t_irq();
    t_framing_error();
    t_overrun();
    t_glitch();
    t_nine();
    t_disable();
    print_verdict();
  end

  // Watchdog well beyond the roughly 27 us the scenarios need
  initial begin
    #400us;
    miscompares++;
    print_verdict();
  end
endmodule
`default_nettype wire
